// ### rtl/uix_consts.vh
// constants for the infrared / nine-bit uart extension block
`ifndef UIX_CONSTS_VH
`define UIX_CONSTS_VH
// oversampling: sixteen ticks per baud period
`define UIX_OVERSAMPLE 16
// infrared transmit pulse width in ticks (3/16 of a baud period)
`define UIX_IR_PULSE_TICKS 3
// shortest accepted infrared pulse in ticks (1/16 of a baud period)
`define UIX_IR_MIN_TICKS 1
// normal-mode majority samples taken at these ticks of a bit
`define UIX_SAMPLE_A 7
`define UIX_SAMPLE_B 8
`define UIX_SAMPLE_C 9
// default baud divisor: one less than the clock cycles per oversample tick
`define UIX_BAUD_DIV 16'h0006
// receive fifo depth
`define UIX_FIFO_DEPTH 8
`endif

// ### rtl/uix_fifo.v
// receive fifo holding data byte plus parity flag
`timescale 1ns/100ps
module uix_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // clock and reset
    input wire clock,
    input wire rst_b,
    // write side
    input wire wr_en,
    input wire [WIDTH-1:0] wr_data,
    // read side
    input wire rd_en,
    output reg [WIDTH-1:0] rd_data,
    output wire empty,
    output wire full
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_ptr;
    reg [AW:0] rd_ptr;

    assign empty = (wr_ptr == rd_ptr);
    assign full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);

    always @(posedge clock) begin
        if (wr_en && !full) begin
            mem[wr_ptr[AW-1:0]] <= wr_data;
        end
    end

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
            rd_data <= {WIDTH{1'b0}};
        end else begin
            if (wr_en && !full) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (rd_en && !empty) begin
                rd_data <= mem[rd_ptr[AW-1:0]];
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule // uix_fifo

// ### rtl/uix_uart.v
// uart core with infrared encoding and nine-bit address interrupt
`timescale 1ns/100ps
`include "uix_consts.vh"
module uix_uart #(
    parameter BAUD_DIV = `UIX_BAUD_DIV,
    parameter FIFO_DEPTH = `UIX_FIFO_DEPTH
) (
    // clock and reset
    input wire clock,
    input wire rst_b,
    // configuration
    input wire [15:0] baud_div,
    input wire parity_enable,
    input wire parity_interrupt_mask,
    input wire fifo_disable,
    input wire ir_mode,
    // transmit request
    input wire tx_valid,
    input wire [7:0] tx_data,
    input wire tx_parity,
    output wire tx_ready,
    // receive word
    input wire rx_read,
    output reg rx_avail,
    output reg [7:0] rx_data,
    output wire received_parity_flag,
    output reg framing_error,
    output wire irq,
    // serial line
    input wire rx_pin,
    output reg tx_pin
);
    // -----------------------------------------------------------------
    // oversample tick
    // -----------------------------------------------------------------
    reg [15:0] div_cnt;
    wire tick = (div_cnt == 16'h0000);
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt <= 16'h0000;
        end else if (tick) begin
            // reload with the divisor itself: a tick every baud_div + 1 clocks
            div_cnt <= baud_div;
        end else begin
            div_cnt <= div_cnt - 16'h0001;
        end
    end

    // -----------------------------------------------------------------
    // transmitter
    // -----------------------------------------------------------------
    localparam TX_IDLE = 2'b01;
    localparam TX_SEND = 2'b10;
    reg [1:0] tx_state;
    reg [10:0] tx_shift;
    reg [3:0] tx_bits;
    reg [3:0] tx_tick;
    assign tx_ready = tx_state[0];
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tx_state <= TX_IDLE;
            tx_shift <= 11'h7ff;
            tx_bits <= 4'h0;
            tx_tick <= 4'h0;
            tx_pin <= 1'b1;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    tx_pin <= 1'b1;
                    if (tx_valid) begin
                        // stop, optional parity data, start
                        tx_shift <= parity_enable ? {1'b1, tx_parity, tx_data, 1'b0}
                                                  : {1'b1, 1'b1, tx_data, 1'b0};
                        tx_bits <= parity_enable ? 4'ha : 4'h9;
                        tx_tick <= 4'h0;
                        tx_state <= TX_SEND;
                    end
                end
                TX_SEND: begin
                    if (ir_mode) begin
                        // zero: low pulse for the first ticks; one: stays high
                        tx_pin <= tx_shift[0] | (tx_tick >= `UIX_IR_PULSE_TICKS);
                    end else begin
                        tx_pin <= tx_shift[0];
                    end
                    if (tick) begin
                        tx_tick <= tx_tick + 4'h1;
                        if (tx_tick == 4'hf) begin
                            tx_shift <= {1'b1, tx_shift[10:1]};
                            if (tx_bits == 4'h0) begin
                                tx_state <= TX_IDLE;
                            end else begin
                                tx_bits <= tx_bits - 4'h1;
                            end
                        end
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // receive line sync and normalisation
    // -----------------------------------------------------------------
    reg rx_meta;
    reg rx_sync;
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
        end else begin
            rx_meta <= rx_pin;
            rx_sync <= rx_meta;
        end
    end
    // receiver state, declared here as the pulse detector reads it
    localparam RX_IDLE = 2'b01;
    localparam RX_DATA = 2'b10;
    reg [1:0] rx_state;
    reg [3:0] rx_tick;
    // infrared: a high pulse is a zero bit; width counted in ticks
    reg [3:0] ir_width;
    reg ir_zero;
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ir_width <= 4'h0;
            ir_zero <= 1'b0;
        end else begin
            if (!rx_sync) begin
                ir_width <= 4'h0;
            end else if (tick && ir_width != 4'hf) begin
                ir_width <= ir_width + 4'h1;
            end
            // glitches shorter than the minimum width never register
            if (rx_sync && tick && ir_width >= `UIX_IR_MIN_TICKS) begin
                ir_zero <= 1'b1;
            end else if (rx_state == RX_IDLE || (tick && rx_tick == 4'hf)) begin
                ir_zero <= 1'b0;
            end
        end
    end
    wire rx_line = ir_mode ? ~ir_zero : rx_sync;

    // -----------------------------------------------------------------
    // receiver
    // -----------------------------------------------------------------
    reg [3:0] rx_bits;
    reg [9:0] rx_shift;
    reg [2:0] votes;
    reg bit_ir;
    reg push;
    reg [8:0] push_word;
    wire vote = (votes[0] & votes[1]) | (votes[1] & votes[2]) | (votes[0] & votes[2]);
    wire [3:0] frame_bits = parity_enable ? 4'ha : 4'h9;
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rx_state <= RX_IDLE;
            rx_tick <= 4'h0;
            rx_bits <= 4'h0;
            rx_shift <= 10'h000;
            votes <= 3'b111;
            bit_ir <= 1'b1;
            push <= 1'b0;
            push_word <= 9'h000;
            framing_error <= 1'b0;
        end else begin
            push <= 1'b0;
            case (rx_state)
                RX_IDLE: begin
                    if (!rx_line) begin
                        rx_state <= RX_DATA;
                        rx_tick <= 4'h0;
                        rx_bits <= 4'h0;
                        bit_ir <= 1'b1;
                    end
                end
                RX_DATA: begin
                    if (tick) begin
                        rx_tick <= rx_tick + 4'h1;
                        // infrared takes one sample mid-pulse, normal takes three
                        if (rx_tick == `UIX_IR_PULSE_TICKS / 2 + 1) begin
                            if (!rx_line) bit_ir <= 1'b0;
                        end
                        if (rx_tick == `UIX_SAMPLE_A) votes[0] <= rx_line;
                        if (rx_tick == `UIX_SAMPLE_B) votes[1] <= rx_line;
                        if (rx_tick == `UIX_SAMPLE_C) votes[2] <= rx_line;
                        if (rx_tick == 4'hf) begin
                            bit_ir <= 1'b1;
                            rx_bits <= rx_bits + 4'h1;
                            rx_shift <= {(ir_mode ? bit_ir : vote), rx_shift[9:1]};
                            if (rx_bits == frame_bits) begin
                                rx_state <= RX_IDLE;
                                framing_error <= ~(ir_mode ? bit_ir : vote);
                                if (ir_mode ? bit_ir : vote) begin
                                    push <= 1'b1;
                                    // drop start bit; parity flag zero when parity is off
                                    push_word <= parity_enable ? rx_shift[9:1]
                                                               : {1'b0, rx_shift[9:2]};
                                end
                            end
                        end
                    end
                end
                default: rx_state <= RX_IDLE;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // receive fifo and holding register
    // -----------------------------------------------------------------
    wire fifo_empty;
    wire [8:0] fifo_out;
    reg held_parity;
    reg loading;
    wire use_fifo = !fifo_disable;
    wire pop = use_fifo && !fifo_empty && (!rx_avail || rx_read) && !loading;
    uix_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH), .AW($clog2(FIFO_DEPTH))) u_fifo (
        .clock(clock),
        .rst_b(rst_b),
        .wr_en(push && use_fifo),
        .wr_data(push_word),
        .rd_en(pop),
        .rd_data(fifo_out),
        .empty(fifo_empty),
        .full()
    );
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rx_avail <= 1'b0;
            rx_data <= 8'h00;
            held_parity <= 1'b0;
            loading <= 1'b0;
        end else begin
            loading <= pop;
            if (loading) begin
                rx_avail <= 1'b1;
                {held_parity, rx_data} <= fifo_out;
            end else if (!use_fifo && push) begin
                // fifo off: new word overwrites, unread non-address words are harmless
                rx_avail <= 1'b1;
                {held_parity, rx_data} <= push_word;
            end else if (rx_read) begin
                rx_avail <= 1'b0;
            end
        end
    end
    // parity flag and interrupt from the held word only
    assign received_parity_flag = rx_avail && held_parity && parity_enable;
    assign irq = parity_interrupt_mask && received_parity_flag;
endmodule // uix_uart

// ### tb/uix_uart_props.sv
// concurrent checks on the uart extension ports
`timescale 1ns/100ps
module uix_uart_props (
    // clock and reset
    input logic clock,
    input logic rst_b,
    // configuration
    input logic [15:0] baud_div,
    input logic parity_enable,
    input logic parity_interrupt_mask,
    input logic fifo_disable,
    input logic ir_mode,
    // data and line
    input logic tx_valid,
    input logic tx_ready,
    input logic rx_read,
    input logic rx_avail,
    input logic received_parity_flag,
    input logic irq,
    input logic tx_pin
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    // saturating, so long normal-mode lows cannot wrap into a false pass
    logic [3:0] low_run;
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b)
            low_run <= 4'h0;
        else if (tx_pin)
            low_run <= 4'h0;
        else if (low_run != 4'hf)
            low_run <= low_run + 4'h1;
    end
    sequence accept_s;
        tx_valid && tx_ready;
    endsequence
    sequence ir_pulse_s;
        !tx_pin [*3] ##1 tx_pin;
    endsequence
    ir_pulse_a: assert property (ir_mode && baud_div == 16'h0000 && $fell(tx_pin) |-> ir_pulse_s)
        else $error("infrared pulse not three ticks");
    ir_low_a: assert property (ir_mode && baud_div == 16'h0000 |-> low_run <= 4'h3)
        else $error("infrared low run too long");
    normal_start_a: assert property (!ir_mode && $fell(tx_pin) |-> !tx_pin [*8])
        else $error("normal low bit too short");
    accept_busy_a: assert property (accept_s |=> !tx_ready [*8])
        else $error("transmitter not busy after accept");
    idle_high_a: assert property (tx_ready |-> tx_pin)
        else $error("idle line not high");
    irq_cause_a: assert property (irq == (parity_interrupt_mask && received_parity_flag))
        else $error("irq does not follow masked parity");
    flag_cause_a: assert property (received_parity_flag |-> parity_enable && rx_avail)
        else $error("parity flag without held word");
    held_word_a: assert property (rx_avail && !rx_read && !fifo_disable
        |=> $stable(received_parity_flag))
        else $error("queued word changed parity flag");
    avail_hold_a: assert property (rx_avail && !rx_read |=> rx_avail)
        else $error("held word lost without read");
endmodule // uix_uart_props

bind uix_uart uix_uart_props u_props (.clock(clock), .rst_b(rst_b), .baud_div(baud_div),
    .parity_enable(parity_enable), .parity_interrupt_mask(parity_interrupt_mask),
    .fifo_disable(fifo_disable), .ir_mode(ir_mode), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_read(rx_read), .rx_avail(rx_avail), .received_parity_flag(received_parity_flag),
    .irq(irq), .tx_pin(tx_pin));

// ### tb/uix_remote.sv
// remote serial node: frame sender and decoder
`timescale 1ns/100ps
module uix_remote (
    // clock
    input logic clock,
    // serial line
    input logic tx_pin,
    output logic rx_pin
);
    logic ir = 1'b0;
    initial rx_pin = 1'b1;
    task mode(input logic m);
        ir = m;
        rx_pin <= !m;
    endtask
    task bit_out(input logic b, input int ticks);
        for (int i = 0; i < 16 * ticks; i++) begin
            rx_pin <= ir ? (!b && i < 3 * ticks) : b;
            @(posedge clock);
        end
    endtask
    task send(input logic [7:0] d, input logic p, input logic par, input int ticks);
        bit_out(1'b0, ticks);
        for (int i = 0; i < 8; i++)
            bit_out(d[i], ticks);
        if (par)
            bit_out(p, ticks);
        bit_out(1'b1, ticks);
    endtask
    task glitch(input int n);
        rx_pin <= 1'b1;
        repeat (n) @(posedge clock);
        rx_pin <= 1'b0;
    endtask
    // decoder only handles one clock per tick
    task recv(output logic [8:0] w, input logic par);
        w = 9'h000;
        while (tx_pin !== 1'b0)
            @(posedge clock);
        for (int k = 0; k < (par ? 10 : 9); k++) begin
            logic b;
            b = 1'b1;
            for (int i = 0; i < 16; i++) begin
                if (tx_pin === 1'b0 && (ir || i == 8))
                    b = 1'b0;
                @(posedge clock);
            end
            if (k > 0)
                w[k - 1] = b;
        end
    endtask
endmodule // uix_remote

// ### tb/uix_uart_test.sv
// self-checking bench for the uart extension block
`timescale 1ns/100ps
module uix_uart_test;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] baud_div = 16'h0000;
    logic parity_enable = 1'b0;
    logic parity_interrupt_mask = 1'b0;
    logic fifo_disable = 1'b0;
    logic ir_mode = 1'b0;
    logic tx_valid = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic tx_parity = 1'b0;
    logic rx_read = 1'b0;
    logic tx_ready, rx_avail, received_parity_flag, framing_error, irq, rx_pin, tx_pin;
    logic [7:0] rx_data;
    int err_total = 0;
    int cmp_count = 0;
    always #2.5 clock = ~clock;
    uix_uart u_dut (.clock(clock), .rst_b(rst_b), .baud_div(baud_div),
        .parity_enable(parity_enable), .parity_interrupt_mask(parity_interrupt_mask),
        .fifo_disable(fifo_disable), .ir_mode(ir_mode), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_parity(tx_parity), .tx_ready(tx_ready), .rx_read(rx_read),
        .rx_avail(rx_avail), .rx_data(rx_data), .received_parity_flag(received_parity_flag),
        .framing_error(framing_error), .irq(irq), .rx_pin(rx_pin), .tx_pin(tx_pin));
    uix_remote u_rem (.clock(clock), .tx_pin(tx_pin), .rx_pin(rx_pin));
    task results;
        if (err_total == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [9:0] got, input logic [9:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task tx_chk(input logic [7:0] d, input logic p, input logic [8:0] exp);
        logic [8:0] w;
        tx_data <= d;
        tx_parity <= p;
        tx_valid <= 1'b1;
        @(posedge clock);
        while (tx_ready !== 1'b1)
            @(posedge clock);
        tx_valid <= 1'b0;
        u_rem.recv(w, parity_enable);
        chk({1'b0, w}, {1'b0, exp});
        while (tx_ready !== 1'b1)
            @(posedge clock);
    endtask
    task rd;
        rx_read <= 1'b1;
        @(posedge clock);
        rx_read <= 1'b0;
        repeat (4) @(posedge clock);
    endtask
    task wait_avail;
        for (int n = 0; n < 400 && rx_avail !== 1'b1; n++)
            @(posedge clock);
    endtask
    task rx_chk(input logic [7:0] d, input logic p, input logic [9:0] exp);
        u_rem.send(d, p, parity_enable, baud_div + 1);
        wait_avail;
        chk({irq, received_parity_flag, rx_data}, exp);
        chk({9'h000, framing_error}, 10'h000);
        rd;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        results;
    end
    initial begin
        repeat (2) @(posedge clock);
        chk({6'h00, tx_pin, tx_ready, rx_avail, irq}, 10'h00c);
        rst_b <= 1'b1;
        parity_enable <= 1'b1;
        parity_interrupt_mask <= 1'b1;
        fifo_disable <= 1'b1;
        @(posedge clock);
        tx_chk(8'ha5, 1'b1, 9'h1a5);
        tx_chk(8'h3c, 1'b0, 9'h03c);
        rx_chk(8'h12, 1'b1, 10'h312);
        rx_chk(8'h34, 1'b0, 10'h034);
        // all-zero frame: the bad stop is flagged and the word dropped
        repeat (11) u_rem.bit_out(1'b0, 1);
        u_rem.bit_out(1'b1, 1);
        chk({8'h00, framing_error, rx_avail}, 10'h002);
        parity_interrupt_mask <= 1'b0;
        @(posedge clock);
        rx_chk(8'h56, 1'b1, 10'h156);
        parity_enable <= 1'b0;
        @(posedge clock);
        rx_chk(8'h78, 1'b1, 10'h078);
        parity_enable <= 1'b1;
        parity_interrupt_mask <= 1'b1;
        fifo_disable <= 1'b0;
        @(posedge clock);
        u_rem.send(8'h21, 1'b0, 1'b1, 1);
        rx_chk(8'hab, 1'b1, 10'h021);
        wait_avail;
        chk({irq, received_parity_flag, rx_data}, 10'h3ab);
        rd;
        // infrared entered under reset so no false pulse is seen mid-frame
        rst_b <= 1'b0;
        parity_enable <= 1'b0;
        fifo_disable <= 1'b1;
        ir_mode <= 1'b1;
        u_rem.mode(1'b1);
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        repeat (200) @(posedge clock);
        if (rx_avail === 1'b1)
            rd;
        tx_chk(8'h5a, 1'b0, 9'h05a);
        rx_chk(8'hc3, 1'b0, 10'h0c3);
        baud_div <= 16'h0003;
        u_rem.glitch(2);
        // longer than a whole frame, so a false start would have delivered a word
        repeat (800) @(posedge clock);
        chk({9'h000, rx_avail}, 10'h000);
        rx_chk(8'h96, 1'b0, 10'h096);
        results;
    end
endmodule // uix_uart_test
